// *** inc/xcp_pkg.sv ***
// Package for the crosspoint configuration port: constants, pin bundles and states.
// Assumes a single core clock; every file refers to it as xcp_pkg::name.
package xcp_pkg;

	localparam int          NUM_PORTS    = 160;
	localparam int          SEL_W        = 8;
	localparam int          DR_LEN       = NUM_PORTS * (SEL_W + 1);
	localparam logic [3:0]  IR_LEN       = 4'h4;
	localparam logic [3:0]  IR_RESET     = 4'h1;
	localparam logic [3:0]  IR_BYPASS    = 4'hF;
	localparam logic [3:0]  IR_CONFIG    = 4'h2;
	localparam logic [3:0]  IR_APPLY     = 4'h3;
	localparam logic [3:0]  IR_CAPTURE   = 4'h1;
	localparam logic [SEL_W-1:0] SEL_RESET = 8'h00;

	typedef enum logic [3:0] {
		TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PA_DR,
		TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR,
		TS_PA_IR, TS_EX2_IR, TS_UPD_IR
	} xcp_tap_state_t;

	typedef struct packed {
		logic trst_n;
		logic tck;
		logic tms;
		logic tdi;
	} xcp_jtag_in_t;

	typedef struct packed {
		logic         drive;
		logic [SEL_W-1:0] sel;
	} xcp_route_t;

endpackage

// *** hdl/xcp_route_mem.sv ***
// Route memory: one entry per switch port, loaded as a whole configuration.
// Assumes the caller presents a full image and a one-cycle load or clear strobe.
`timescale 1ns/10ps
module xcp_route_mem (
	input  wire logic                                   CORE_CLK,
	input  wire logic                                   SRST,
	input  wire logic                                   clr,
	input  wire logic                                   load,
	input  wire logic [xcp_pkg::DR_LEN-1:0]             image,
	output xcp_pkg::xcp_route_t [xcp_pkg::NUM_PORTS-1:0] route
);

	genvar g;
	generate
		for (g = 0; g < xcp_pkg::NUM_PORTS; g++) begin : g_ent
			always_ff @(posedge CORE_CLK) begin
				if (SRST || clr) begin
					route[g] <= '{drive: 1'b0, sel: xcp_pkg::SEL_RESET};
				end else if (load) begin
					route[g] <= image[g*(xcp_pkg::SEL_W+1) +: (xcp_pkg::SEL_W+1)];
				end
			end
		end
	endgenerate

endmodule

// *** hdl/xcp_config_port.sv ***
// Crosspoint switch with its serial test-port configuration loader.
// Assumes the pins come from another domain; they are synchronised to CORE_CLK here.
`timescale 1ns/10ps
module xcp_config_port (
	input  wire logic                         CORE_CLK,
	input  wire logic                         SRST,
	input  xcp_pkg::xcp_jtag_in_t             JTAG_IN,
	output logic                              TDO,
	output logic                              TDO_OE_N,
	input  wire logic [xcp_pkg::NUM_PORTS-1:0] PORT_IN,
	output logic [xcp_pkg::NUM_PORTS-1:0]     PORT_OUT,
	output logic [xcp_pkg::NUM_PORTS-1:0]     PORT_OE_N
);

	xcp_pkg::xcp_jtag_in_t s1_r;
	xcp_pkg::xcp_jtag_in_t s2_r;
	logic                  tck_d_r;
	logic                  rise;
	logic                  fall;
	logic                  trst_act;
	xcp_pkg::xcp_tap_state_t st_r;
	xcp_pkg::xcp_tap_state_t st_nxt;
	logic [3:0]            ir_sh_r;
	logic [3:0]            ir_r;
	logic [xcp_pkg::DR_LEN-1:0] dr_r;
	logic                  byp_r;
	logic                  tdo_r;
	logic                  tdo_en_r;
	logic                  shift_out;
	logic                  mem_clr;
	logic                  mem_load;
	xcp_pkg::xcp_route_t [xcp_pkg::NUM_PORTS-1:0] route;
	logic [xcp_pkg::DR_LEN-1:0] cap_img;

	// Two flip-flops before any logic reads the pins.
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			s1_r <= '{trst_n: 1'b0, tck: 1'b0, tms: 1'b1, tdi: 1'b1};
			s2_r <= '{trst_n: 1'b0, tck: 1'b0, tms: 1'b1, tdi: 1'b1};
		end else begin
			s1_r <= JTAG_IN;
			s2_r <= s1_r;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			tck_d_r <= 1'b0;
		end else begin
			tck_d_r <= s2_r.tck;
		end
	end

	assign rise     = s2_r.tck & ~tck_d_r;
	assign fall     = ~s2_r.tck & tck_d_r;
	assign trst_act = SRST | ~s2_r.trst_n;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			xcp_pkg::TS_RESET:  st_nxt = s2_r.tms ? xcp_pkg::TS_RESET  : xcp_pkg::TS_IDLE;
			xcp_pkg::TS_IDLE:   st_nxt = s2_r.tms ? xcp_pkg::TS_SEL_DR : xcp_pkg::TS_IDLE;
			xcp_pkg::TS_SEL_DR: st_nxt = s2_r.tms ? xcp_pkg::TS_SEL_IR : xcp_pkg::TS_CAP_DR;
			xcp_pkg::TS_CAP_DR: st_nxt = s2_r.tms ? xcp_pkg::TS_EX1_DR : xcp_pkg::TS_SH_DR;
			xcp_pkg::TS_SH_DR:  st_nxt = s2_r.tms ? xcp_pkg::TS_EX1_DR : xcp_pkg::TS_SH_DR;
			xcp_pkg::TS_EX1_DR: st_nxt = s2_r.tms ? xcp_pkg::TS_UPD_DR : xcp_pkg::TS_PA_DR;
			xcp_pkg::TS_PA_DR:  st_nxt = s2_r.tms ? xcp_pkg::TS_EX2_DR : xcp_pkg::TS_PA_DR;
			xcp_pkg::TS_EX2_DR: st_nxt = s2_r.tms ? xcp_pkg::TS_UPD_DR : xcp_pkg::TS_SH_DR;
			xcp_pkg::TS_UPD_DR: st_nxt = s2_r.tms ? xcp_pkg::TS_SEL_DR : xcp_pkg::TS_IDLE;
			xcp_pkg::TS_SEL_IR: st_nxt = s2_r.tms ? xcp_pkg::TS_RESET  : xcp_pkg::TS_CAP_IR;
			xcp_pkg::TS_CAP_IR: st_nxt = s2_r.tms ? xcp_pkg::TS_EX1_IR : xcp_pkg::TS_SH_IR;
			xcp_pkg::TS_SH_IR:  st_nxt = s2_r.tms ? xcp_pkg::TS_EX1_IR : xcp_pkg::TS_SH_IR;
			xcp_pkg::TS_EX1_IR: st_nxt = s2_r.tms ? xcp_pkg::TS_UPD_IR : xcp_pkg::TS_PA_IR;
			xcp_pkg::TS_PA_IR:  st_nxt = s2_r.tms ? xcp_pkg::TS_EX2_IR : xcp_pkg::TS_PA_IR;
			xcp_pkg::TS_EX2_IR: st_nxt = s2_r.tms ? xcp_pkg::TS_UPD_IR : xcp_pkg::TS_SH_IR;
			xcp_pkg::TS_UPD_IR: st_nxt = s2_r.tms ? xcp_pkg::TS_SEL_DR : xcp_pkg::TS_IDLE;
			default:            st_nxt = xcp_pkg::TS_RESET;
		endcase
	end

	// The controller advances only on rising clock edges.
	always_ff @(posedge CORE_CLK) begin
		if (trst_act) begin
			st_r <= xcp_pkg::TS_RESET;
		end else if (rise) begin
			st_r <= st_nxt;
		end
	end

	// Instruction register.
	always_ff @(posedge CORE_CLK) begin
		if (trst_act || (rise && st_r == xcp_pkg::TS_RESET)) begin
			ir_sh_r <= xcp_pkg::IR_RESET;
			ir_r    <= xcp_pkg::IR_RESET;
		end else if (rise) begin
			if (st_r == xcp_pkg::TS_CAP_IR) begin
				ir_sh_r <= xcp_pkg::IR_CAPTURE;
			end else if (st_r == xcp_pkg::TS_SH_IR) begin
				ir_sh_r <= {s2_r.tdi, ir_sh_r[3:1]};
			end else if (st_r == xcp_pkg::TS_UPD_IR) begin
				ir_r <= ir_sh_r;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < xcp_pkg::NUM_PORTS; g++) begin : g_cap
			assign cap_img[g*(xcp_pkg::SEL_W+1) +: (xcp_pkg::SEL_W+1)] = route[g];
		end
	endgenerate

	// Configuration data register, loaded least significant bit first.
	always_ff @(posedge CORE_CLK) begin
		if (trst_act) begin
			dr_r  <= '0;
			byp_r <= 1'b0;
		end else if (rise) begin
			if (st_r == xcp_pkg::TS_CAP_DR) begin
				// Only the configuration instruction captures, so a shifted image survives to apply.
				if (ir_r == xcp_pkg::IR_CONFIG) begin
					dr_r <= cap_img;
				end
				byp_r <= 1'b0;
			end else if (st_r == xcp_pkg::TS_SH_DR) begin
				if (ir_r == xcp_pkg::IR_CONFIG) begin
					dr_r <= {s2_r.tdi, dr_r[xcp_pkg::DR_LEN-1:1]};
				end
				byp_r <= s2_r.tdi;
			end
		end
	end

	assign mem_clr  = trst_act | (rise && st_r == xcp_pkg::TS_RESET);
	assign mem_load = rise && st_r == xcp_pkg::TS_UPD_DR && ir_r == xcp_pkg::IR_APPLY;

	xcp_route_mem u_mem (
		.CORE_CLK (CORE_CLK),
		.SRST     (SRST),
		.clr      (mem_clr),
		.load     (mem_load),
		.image    (dr_r),
		.route    (route)
	);

	always_comb begin
		shift_out = byp_r;
		if (st_r == xcp_pkg::TS_SH_IR) begin
			shift_out = ir_sh_r[0];
		end else if (ir_r == xcp_pkg::IR_CONFIG) begin
			shift_out = dr_r[0];
		end
	end

	// Serial output updates only on falling clock edges.
	always_ff @(posedge CORE_CLK) begin
		if (trst_act) begin
			tdo_r    <= 1'b0;
			tdo_en_r <= 1'b0;
		end else if (fall) begin
			tdo_r    <= shift_out;
			tdo_en_r <= (st_r == xcp_pkg::TS_SH_DR) || (st_r == xcp_pkg::TS_SH_IR);
		end
	end

	assign TDO      = tdo_r;
	assign TDO_OE_N = ~tdo_en_r;

	// Each driving port copies its selected source port; a select of 160 or above gives 0.
	logic [xcp_pkg::NUM_PORTS-1:0] out_r;
	logic [xcp_pkg::NUM_PORTS-1:0] oe_n_r;
	logic [xcp_pkg::NUM_PORTS-1:0] pin1_r;
	logic [xcp_pkg::NUM_PORTS-1:0] pin2_r;

	// Two flip-flops before the switch reads the port pins.
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			pin1_r <= '0;
			pin2_r <= '0;
		end else begin
			pin1_r <= PORT_IN;
			pin2_r <= pin1_r;
		end
	end

	generate
		for (g = 0; g < xcp_pkg::NUM_PORTS; g++) begin : g_sw
			always_ff @(posedge CORE_CLK) begin
				if (SRST) begin
					out_r[g]  <= 1'b0;
					oe_n_r[g] <= 1'b1;
				end else begin
					if (route[g].sel < xcp_pkg::NUM_PORTS) begin
						out_r[g] <= pin2_r[route[g].sel];
					end else begin
						out_r[g] <= 1'b0;
					end
					oe_n_r[g] <= ~route[g].drive;
				end
			end
		end
	endgenerate

	assign PORT_OUT  = out_r;
	assign PORT_OE_N = oe_n_r;

endmodule

// *** verif/xcp_cfg_checker.sv ***
// Assertions on the ports of the crosspoint configuration port.
// Assumes the test clock pin rests low outside frames.
`timescale 1ns/10ps
module xcp_cfg_checker (
	input wire logic                          CORE_CLK,
	input wire logic                          SRST,
	input xcp_pkg::xcp_jtag_in_t              JTAG_IN,
	input wire logic                          TDO,
	input wire logic                          TDO_OE_N,
	input wire logic [xcp_pkg::NUM_PORTS-1:0] PORT_OUT,
	input wire logic [xcp_pkg::NUM_PORTS-1:0] PORT_OE_N
);
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (SRST);
	a_srst_ports: assert property ($fell(SRST) |-> &PORT_OE_N && PORT_OUT == '0)
		else $error("ports not idle after reset");
	a_srst_serial: assert property ($fell(SRST) |-> TDO_OE_N && !TDO)
		else $error("serial out not idle after reset");
	a_trst_ports: assert property (!JTAG_IN.trst_n [*8] |-> &PORT_OE_N)
		else $error("ports drive during test reset");
	a_trst_serial: assert property (!JTAG_IN.trst_n [*6] |-> TDO_OE_N && !TDO)
		else $error("serial out active during test reset");
	a_tdo_on_fall: assert property ($changed(TDO) |-> !$past(JTAG_IN.tck, 2))
		else $error("serial out moved outside clock low phase");
	a_route_on_rise: assert property ($changed(PORT_OE_N) |->
		$past(JTAG_IN.tck, 2) || !$past(JTAG_IN.trst_n, 3))
		else $error("routes changed away from a clock rise");
	c_port_drives: cover property ($fell(PORT_OE_N[0]));
	c_serial_on: cover property ($fell(TDO_OE_N));
	c_tdo_high: cover property ($rose(TDO));
endmodule

bind xcp_config_port xcp_cfg_checker xcp_cfg_checker_i (.CORE_CLK(CORE_CLK), .SRST(SRST),
	.JTAG_IN(JTAG_IN), .TDO(TDO), .TDO_OE_N(TDO_OE_N), .PORT_OUT(PORT_OUT),
	.PORT_OE_N(PORT_OE_N));

// *** verif/xcp_jtag_drv.sv ***
// Processor-side model that bit-bangs the test port pins.
// Assumes the bench calls one task at a time; the clock rests low between frames.
`timescale 1ns/10ps
module xcp_jtag_drv (
	output xcp_pkg::xcp_jtag_in_t pins,
	input  wire logic             tdo
);
	logic                       last_tdo;
	logic [xcp_pkg::DR_LEN-1:0] rd_bits;
	initial pins = 4'h8;
	task automatic step(input logic m, input logic d);
		pins.tms = m;
		pins.tdi = d;
		#200 last_tdo = tdo;
		pins.tck = 1'b1;
		#200 pins.tck = 1'b0;
	endtask
	task automatic seq(input logic [7:0] m, input int n);
		for (int i = 0; i < n; i++) begin
			step(m[i], 1'b0);
		end
	endtask
	task automatic pulse_reset();
		pins.trst_n = 1'b0;
		#800 pins.trst_n = 1'b1;
		step(1'b0, 1'b0);
	endtask
	task automatic shift(input logic [xcp_pkg::DR_LEN-1:0] v, input int n, input logic ir);
		seq(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i]);
			rd_bits[i] = last_tdo;
		end
		seq(8'h01, 2);
	endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the crosspoint configuration port.
// Assumes the processor model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tb;
	logic                          core_clk;
	logic                          srst;
	xcp_pkg::xcp_jtag_in_t         jin;
	logic                          tdo;
	logic                          tdo_oe_n;
	logic [xcp_pkg::NUM_PORTS-1:0] pin;
	logic [xcp_pkg::NUM_PORTS-1:0] pout;
	logic [xcp_pkg::NUM_PORTS-1:0] poe_n;
	logic [xcp_pkg::DR_LEN-1:0]    img;
	logic [7:0]                    byp;
	int                            err_count;
	int                            cmp_count;
	int                            cyc;
	xcp_config_port xcp_config_port_i (.CORE_CLK(core_clk), .SRST(srst), .JTAG_IN(jin),
		.TDO(tdo), .TDO_OE_N(tdo_oe_n), .PORT_IN(pin), .PORT_OUT(pout), .PORT_OE_N(poe_n));
	// A released serial output shows the inverse of its last value to the processor model.
	xcp_jtag_drv xcp_jtag_drv_i (.pins(jin), .tdo(tdo_oe_n ? ~tdo : tdo));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic chk(input logic [159:0] got, input logic [159:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [159:0] exp_oe(input logic [1439:0] im);
		for (int g = 0; g < 160; g++) begin
			exp_oe[g] = ~im[9*g+8];
		end
	endfunction
	function automatic logic [159:0] exp_out(input logic [1439:0] im, input logic [159:0] p);
		for (int g = 0; g < 160; g++) begin
			exp_out[g] = p[im[9*g+:8]];
		end
	endfunction
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		srst = 1'b1;
		pin = '0;
		err_count = 0;
		cmp_count = 0;
		cyc = 0;
		void'($urandom(81550));
		repeat (12) @(posedge core_clk);
		#1 srst = 1'b0;
		@(posedge core_clk);
		#1 chk(poe_n, '1);
		chk({159'h0, tdo_oe_n}, 160'h1);
		for (int t = 0; t < 2; t++) begin
			for (int g = 0; g < 160; g++) begin
				img[9*g+:9] = {1'($urandom), 8'($urandom_range(159, 0))};
			end
			img[8:0] = 9'h19F;
			img[1439:1431] = 9'h100;
			xcp_jtag_drv_i.pulse_reset();
			#1 chk(poe_n, '1);
			xcp_jtag_drv_i.shift({1436'h0, xcp_pkg::IR_CONFIG}, 4, 1'b1);
			chk(160'(xcp_jtag_drv_i.rd_bits[3:0]), 160'(xcp_pkg::IR_CAPTURE));
			xcp_jtag_drv_i.shift(img, xcp_pkg::DR_LEN, 1'b0);
			chk(xcp_jtag_drv_i.rd_bits[159:0], '0);
			xcp_jtag_drv_i.shift({1436'h0, xcp_pkg::IR_APPLY}, 4, 1'b1);
			xcp_jtag_drv_i.seq(8'h0D, 5);
			#1 chk(poe_n, exp_oe(img));
			repeat (4) begin
				@(posedge core_clk);
				#1 pin = {$urandom, $urandom, $urandom, $urandom, $urandom};
				repeat (3) @(posedge core_clk);
				#1 chk(pout, exp_out(img, pin));
			end
			xcp_jtag_drv_i.shift({1436'h0, xcp_pkg::IR_CONFIG}, 4, 1'b1);
			xcp_jtag_drv_i.shift('0, 160, 1'b0);
			chk(xcp_jtag_drv_i.rd_bits[159:0], img[159:0]);
			$display("load %0d done", t);
		end
		byp = 8'($urandom);
		xcp_jtag_drv_i.shift({1436'h0, xcp_pkg::IR_BYPASS}, 4, 1'b1);
		xcp_jtag_drv_i.shift(1440'(byp), 8, 1'b0);
		chk(160'(xcp_jtag_drv_i.rd_bits[7:0]), 160'({byp[6:0], 1'b0}));
		$display("bypass done");
		xcp_jtag_drv_i.seq(8'h1F, 6);
		#1 chk(poe_n, '1);
		$display("mode reset done");
		summarize();
	end
endmodule
